// ---- src/mcs_pkg.sv ----
/*
  Constants for the MII carrier sense and collision status block.
  Assumes a single 20 MHz clock; all inputs synchronous to it.
*/
package mcs_pkg;
  localparam int unsigned MCS_CLK_HZ = 20000000;
  localparam int unsigned MCS_SYM_BITS = 10;
  // SQE test pulse length in ns, and its length in clock cycles
  localparam int unsigned MCS_SQE_NS = 1000;
  localparam int unsigned MCS_CLK_NS = 1000000000 / MCS_CLK_HZ;
  localparam int unsigned MCS_SQE_CYC_I = MCS_SQE_NS / MCS_CLK_NS;
  localparam logic [7:0] MCS_SQE_CYC = 8'(MCS_SQE_CYC_I);
  localparam logic [7:0] MCS_CNT_ZERO = 8'h00;
  localparam logic [7:0] MCS_CNT_ONE = 8'h01;
  localparam logic [9:0] MCS_SYM_RST = 10'h3ff;
  localparam logic [3:0] MCS_ZC_ZERO = 4'h0;
  localparam logic [3:0] MCS_ZC_ONE = 4'h1;
  localparam logic [3:0] MCS_ZC_MIN = 4'h2;
  // Bit position of the SQE test inhibit bit in its control register
  localparam int unsigned MCS_SQE_INH_BIT = 2;
  localparam int unsigned MCS_SQE_INH_REG = 18;
  typedef enum logic [1:0] {
    MCS_SQE_IDLE = 2'b00,
    MCS_SQE_WAIT = 2'b01,
    MCS_SQE_PULSE = 2'b10
  } mcs_sqe_type;
endpackage

// ---- src/mcs_status.sv ----
/*
  Carrier sense, collision and speed indicator logic toward the MAC.
  Assumes every input is synchronous to clock; the MAC resynchronises
  col and crs itself since they carry no relation to its MII clocks.
*/
// Contract
// [RULE_01] Speed indicator low in 10 Mb/s, high in 100 Mb/s.
// [RULE_02] Held in reset while chip_rst_low is low, operational when high.
// [RULE_03] Assert col on receive activity while tx_en is high.
// [RULE_04] 10 Mb/s receive activity comes from the unsquelched line signal.
// [RULE_05] 100 Mb/s activity: two non-adjacent zeros within a 10-bit symbol.
// [RULE_06] col has no timing relation to MII clocks; MAC synchronises it.
// [RULE_07] Full duplex holds col low permanently.
// [RULE_08] col asserts for SQE test unless the inhibit bit is set.
// [RULE_09] Half duplex: crs on receive or transmit activity.
// [RULE_10] Full duplex or repeater: crs on receive activity only.
// [RULE_11] crs has no timing relation to MII clocks; MAC synchronises it.
// [RULE_12] Management clock comes from the station manager.
// [RULE_13] col and crs stay low while hardware reset is held.
`timescale 1ns/1ps
module mcs_status
  import mcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic chip_rst_low,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic repeater_mode,
  input wire logic sqe_test_inhibit,
  input wire logic tx_en,
  input wire logic line_rx_unsquelched,
  input wire logic line_rx_bit,
  input wire logic line_rx_bit_valid,
  input wire logic tx_end,
  input wire logic mgmt_clk,
  output logic col,
  output logic crs,
  output logic speed_indicator_out,
  output logic mgmt_clk_out
);
  logic run;
  logic [9:0] sym_r, sym_nxt;
  logic act100_r, act100_nxt;
  logic rx_act;
  logic col_r, col_nxt;
  logic crs_r, crs_nxt;
  logic spd_r, spd_nxt;
  mcs_sqe_type sqe_r, sqe_nxt;
  logic [7:0] sqe_cnt_r, sqe_cnt_nxt;

  // [RULE_02] Reset gating
  assign run = rst_b & chip_rst_low;

  // Returns true when two zeros exist with at least one bit between them
  function automatic logic two_apart_zeros(input logic [9:0] s);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < MCS_SYM_BITS; i++) begin
      for (int j = i + 2; j < MCS_SYM_BITS; j++) begin
        if (!s[i] && !s[j]) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction

  // [RULE_05] Symbol window
  always_comb begin
    sym_nxt = sym_r;
    act100_nxt = act100_r;
    if (line_rx_bit_valid) begin
      sym_nxt = {sym_r[8:0], line_rx_bit};
      // Sliding window so symbols at any alignment are seen
      act100_nxt = two_apart_zeros({sym_r[8:0], line_rx_bit});
    end
  end

  always_ff @(posedge clock) begin
    if (!run) begin
      sym_r <= MCS_SYM_RST;
      act100_r <= 1'b0;
    end else begin
      sym_r <= sym_nxt;
      act100_r <= act100_nxt;
    end
  end

  // [RULE_04] Unsquelched line in 10 Mb/s
  assign rx_act = speed_100 ? act100_r : line_rx_unsquelched;

  // SQE test: after a transmission ends in 10 Mb/s half duplex, pulse col
  always_comb begin
    sqe_nxt = sqe_r;
    sqe_cnt_nxt = sqe_cnt_r;
    unique case (sqe_r)
      MCS_SQE_IDLE: begin
        if (tx_end && !speed_100 && !full_duplex) begin
          sqe_nxt = MCS_SQE_PULSE;
          sqe_cnt_nxt = MCS_SQE_CYC;
        end
      end
      MCS_SQE_PULSE: begin
        sqe_cnt_nxt = sqe_cnt_r - MCS_CNT_ONE;
        if (sqe_cnt_r == MCS_CNT_ONE) begin
          sqe_nxt = MCS_SQE_IDLE;
          sqe_cnt_nxt = MCS_CNT_ZERO;
        end
      end
      default: begin
        sqe_nxt = MCS_SQE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!run) begin
      sqe_r <= MCS_SQE_IDLE;
      sqe_cnt_r <= MCS_CNT_ZERO;
    end else begin
      sqe_r <= sqe_nxt;
      sqe_cnt_r <= sqe_cnt_nxt;
    end
  end

  always_comb begin
    col_nxt = 1'b0;
    crs_nxt = rx_act;
    spd_nxt = speed_100;
    // [RULE_03] Receive during transmit
    if (rx_act && tx_en) begin
      col_nxt = 1'b1;
    end
    // [RULE_08] SQE unless inhibited
    if (sqe_r == MCS_SQE_PULSE && !sqe_test_inhibit) begin
      col_nxt = 1'b1;
    end
    // [RULE_07] Full duplex masks col
    if (full_duplex) begin
      col_nxt = 1'b0;
    end
    // [RULE_09] [RULE_10] Transmit feeds crs only in half duplex outside repeater mode
    if (!full_duplex && !repeater_mode && tx_en) begin
      crs_nxt = 1'b1;
    end
  end

  // [RULE_13] col, crs and speed indicator low in reset
  always_ff @(posedge clock) begin
    if (!run) begin
      col_r <= 1'b0;
      crs_r <= 1'b0;
      spd_r <= 1'b0;
    end else begin
      col_r <= col_nxt;
      crs_r <= crs_nxt;
      spd_r <= spd_nxt;
    end
  end

  // [RULE_06] Registered, no MII clock relation
  assign col = col_r;
  // [RULE_11] Registered, no MII clock relation
  assign crs = crs_r;
  // [RULE_01] Speed indicator
  assign speed_indicator_out = spd_r;
  // [RULE_12] Management clock taken from the station manager, passed on
  assign mgmt_clk_out = mgmt_clk;

  // Checks hold only while both resets are released, unless noted
  localparam int MCS_SQE_SPAN = MCS_SQE_CYC_I;

  sequence s_zero_bit;
    line_rx_bit_valid && !line_rx_bit;
  endsequence

  // Zero, one more bit, zero: the tightest pair of non-adjacent zeros
  sequence s_spread_zeros;
    s_zero_bit ##2 line_rx_bit_valid ##2 s_zero_bit;
  endsequence

  sequence s_collide;
    !full_duplex && tx_en && rx_act;
  endsequence

  sequence s_sqe_start;
    tx_end && !speed_100 && !full_duplex && (sqe_r == MCS_SQE_IDLE);
  endsequence

  sequence s_sqe_shown;
    !sqe_test_inhibit && !full_duplex;
  endsequence

  // [RULE_07] Full duplex mask
  property p_col_fd;
    @(posedge clock) disable iff (!run)
      full_duplex |=> !col;
  endproperty
  a_col_fd: assert property (p_col_fd) else $error("col high in full duplex"); // [RULE_07]

  // [RULE_01] Speed follows selection
  property p_speed;
    @(posedge clock) disable iff (!rst_b) chip_rst_low ##1 chip_rst_low |->
      speed_indicator_out == $past(speed_100);
  endproperty
  a_speed: assert property (p_speed) else $error("speed out wrong"); // [RULE_01]

  // [RULE_13] Quiet in reset
  property p_rst_quiet;
    @(posedge clock) !chip_rst_low |=> !col && !crs;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset"); // [RULE_13]

  // [RULE_02] Held in reset
  property p_spd_rst;
    @(posedge clock) !run |=> !speed_indicator_out;
  endproperty
  a_spd_rst: assert property (p_spd_rst) else $error("speed out active in reset"); // [RULE_02]

  // [RULE_03] Collision on overlap
  property p_col_cause;
    @(posedge clock) disable iff (!run)
      s_collide |=> col;
  endproperty
  a_col_cause: assert property (p_col_cause) else $error("collision missed"); // [RULE_03]

  // [RULE_03] No collision without cause
  property p_col_quiet;
    @(posedge clock) disable iff (!run)
      (sqe_r != MCS_SQE_PULSE) && !(tx_en && rx_act) |=> !col;
  endproperty
  a_col_quiet: assert property (p_col_quiet) else $error("col without cause"); // [RULE_03]

  // [RULE_09] Transmit carrier
  property p_crs_half;
    @(posedge clock) disable iff (!run)
      run && !full_duplex && !repeater_mode && tx_en |=> crs;
  endproperty
  a_crs_half: assert property (p_crs_half) else $error("crs missed on tx"); // [RULE_09]

  // [RULE_09] Idle line, no carrier
  property p_crs_idle;
    @(posedge clock) disable iff (!run)
      !rx_act && !tx_en |=> !crs;
  endproperty
  a_crs_idle: assert property (p_crs_idle) else $error("crs while idle"); // [RULE_09]

  // [RULE_10] Transmit ignored
  property p_crs_fd;
    @(posedge clock) disable iff (!run)
      run && (full_duplex || repeater_mode) && !rx_act |=> !crs;
  endproperty
  a_crs_fd: assert property (p_crs_fd) else $error("crs from tx in fd"); // [RULE_10]

  // [RULE_10] Receive carrier
  property p_crs_rx;
    @(posedge clock) disable iff (!run)
      rx_act |=> crs;
  endproperty
  a_crs_rx: assert property (p_crs_rx) else $error("crs missed on rx"); // [RULE_10]

  // [RULE_08] Inhibit hides pulse
  property p_sqe_inh;
    @(posedge clock) disable iff (!run)
      run && sqe_test_inhibit && !(tx_en && rx_act) |=> !col;
  endproperty
  a_sqe_inh: assert property (p_sqe_inh) else $error("sqe not inhibited"); // [RULE_08]

  // [RULE_08] Pulse shown on col
  property p_sqe_col;
    @(posedge clock) disable iff (!run)
      s_sqe_start ##1 s_sqe_shown |=> col;
  endproperty
  a_sqe_col: assert property (p_sqe_col) else $error("sqe pulse missing"); // [RULE_08]

  // [RULE_08] Pulse length
  property p_sqe_len;
    @(posedge clock) disable iff (!run)
      s_sqe_start |=> (sqe_r == MCS_SQE_PULSE) ##MCS_SQE_SPAN (sqe_r == MCS_SQE_IDLE);
  endproperty
  a_sqe_len: assert property (p_sqe_len) else $error("sqe pulse length"); // [RULE_08]

  // [RULE_08] Pulse only in 10M half
  property p_sqe_mode;
    @(posedge clock) disable iff (!run)
      tx_end && (speed_100 || full_duplex) && (sqe_r == MCS_SQE_IDLE) |=>
        (sqe_r == MCS_SQE_IDLE);
  endproperty
  a_sqe_mode: assert property (p_sqe_mode) else $error("sqe outside 10M half"); // [RULE_08]

  // [RULE_04] Unsquelched line collides
  property p_act10;
    @(posedge clock) disable iff (!run)
      !speed_100 && line_rx_unsquelched && tx_en && !full_duplex |=> col;
  endproperty
  a_act10: assert property (p_act10) else $error("10M activity source"); // [RULE_04]

  // [RULE_05] Spread zeros detected
  property p_act100;
    @(posedge clock) disable iff (!run)
      s_spread_zeros |=> act100_r;
  endproperty
  a_act100: assert property (p_act100) else $error("100M activity missed"); // [RULE_05]

  // [RULE_05] Activity moves only on bits
  property p_act100_hold;
    @(posedge clock) disable iff (!run)
      !line_rx_bit_valid |=> $stable(act100_r);
  endproperty
  a_act100_hold: assert property (p_act100_hold) else $error("100M activity moved"); // [RULE_05]
endmodule

// ---- testbench/mcs_mac_model.sv ----
/* MAC and station manager model: sources the management clock, resyncs col and crs.
   Assumes it shares the bench clock. */
`timescale 1ns/1ps
module mcs_mac_model (
  input wire logic clock,
  input wire logic col,
  input wire logic crs,
  output logic mgmt_clk,
  output logic col_sync,
  output logic crs_sync
);
  logic [1:0] div_r = 2'h0;
  logic [1:0] col_r = 2'h0;
  logic [1:0] crs_r = 2'h0;
  assign mgmt_clk = div_r[1];
  always_ff @(posedge clock) begin
    div_r <= div_r + 2'h1;
    col_r <= {col_r[0], col};
    crs_r <= {crs_r[0], crs};
  end
  assign col_sync = col_r[1];
  assign crs_sync = crs_r[1];
endmodule

// ---- testbench/tb.sv ----
/* Self-checking bench for the carrier sense and collision block.
   Assumes inputs are driven on the falling edge and outputs read there. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb;
  import mcs_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic chip_rst_low = 1'b1;
  logic speed_100 = 1'b0;
  logic full_duplex = 1'b0;
  logic repeater_mode = 1'b0;
  logic sqe_test_inhibit = 1'b0;
  logic tx_en = 1'b0;
  logic rx = 1'b0;
  logic rx_bit = 1'b1;
  logic rx_valid = 1'b0;
  logic tx_end = 1'b0;
  logic mgmt_clk, col, crs, spd, mclk_out, col_sync, crs_sync;
  int mismatches = 0;
  int checked = 0;
  always #25 clock = ~clock;
  mcs_status i_mcs_status (.clock(clock), .rst_b(rst_b), .chip_rst_low(chip_rst_low),
    .speed_100(speed_100), .full_duplex(full_duplex), .repeater_mode(repeater_mode),
    .sqe_test_inhibit(sqe_test_inhibit), .tx_en(tx_en), .line_rx_unsquelched(rx),
    .line_rx_bit(rx_bit), .line_rx_bit_valid(rx_valid), .tx_end(tx_end),
    .mgmt_clk(mgmt_clk), .col(col), .crs(crs), .speed_indicator_out(spd),
    .mgmt_clk_out(mclk_out));
  mcs_mac_model i_mcs_mac_model (.clock(clock), .col(col), .crs(crs),
    .mgmt_clk(mgmt_clk), .col_sync(col_sync), .crs_sync(crs_sync));
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task snd(input logic b);
    rx_bit = b;
    rx_valid = 1'b1;
    cyc(1);
    rx_valid = 1'b0;
    rx_bit = 1'b1;
    cyc(1);
  endtask
  task wcrs(input logic v);
    for (int i = 0; i < 8 && crs !== v; i++) cyc(1);
    `CHK("crs", v, crs)
    if (crs !== v) conclude();
  endtask
  task t_speed;
    speed_100 = 1'b1;
    cyc(1);
    `CHK("speed", 1'b1, spd)
    speed_100 = 1'b0;
    cyc(1);
    `CHK("speed", 1'b0, spd)
    for (int i = 0; i < 6; i++) begin
      `CHK("mgmt", mgmt_clk, mclk_out)
      cyc(1);
    end
  endtask
  task t_col10;
    tx_en = 1'b1;
    rx = 1'b1;
    cyc(1);
    `CHK("col", 1'b1, col)
    `CHK("crs", 1'b1, crs)
    cyc(2);
    `CHK("col_sync", 1'b1, col_sync)
    `CHK("crs_sync", 1'b1, crs_sync)
    tx_en = 1'b0;
    cyc(1);
    `CHK("col", 1'b0, col)
    `CHK("crs", 1'b1, crs)
    rx = 1'b0;
    tx_en = 1'b1;
    cyc(1);
    `CHK("crs", 1'b1, crs)
    tx_en = 1'b0;
    cyc(1);
    `CHK("crs", 1'b0, crs)
  endtask
  task t_fd;
    full_duplex = 1'b1;
    tx_en = 1'b1;
    rx = 1'b1;
    cyc(1);
    `CHK("col", 1'b0, col)
    `CHK("crs", 1'b1, crs)
    rx = 1'b0;
    cyc(1);
    `CHK("crs", 1'b0, crs)
    full_duplex = 1'b0;
    repeater_mode = 1'b1;
    cyc(1);
    `CHK("crs", 1'b0, crs)
    repeater_mode = 1'b0;
    tx_en = 1'b0;
    cyc(1);
  endtask
  task t_sqe(input logic inh);
    sqe_test_inhibit = inh;
    tx_end = 1'b1;
    cyc(1);
    tx_end = 1'b0;
    cyc(1);
    for (int i = 0; i < 20; i++) begin
      `CHK("col", ~inh, col)
      cyc(1);
    end
    `CHK("col", 1'b0, col)
    sqe_test_inhibit = 1'b0;
  endtask
  task t_100;
    speed_100 = 1'b1;
    tx_end = 1'b1;
    cyc(1);
    tx_end = 1'b0;
    cyc(1);
    `CHK("col", 1'b0, col)
    snd(1'b0);
    snd(1'b0);
    `CHK("crs", 1'b0, crs)
    snd(1'b1);
    snd(1'b0);
    wcrs(1'b1);
    tx_en = 1'b1;
    cyc(1);
    `CHK("col", 1'b1, col)
    tx_en = 1'b0;
    repeat (10) snd(1'b1);
    wcrs(1'b0);
    speed_100 = 1'b0;
  endtask
  task t_rst;
    tx_en = 1'b1;
    rx = 1'b1;
    chip_rst_low = 1'b0;
    cyc(2);
    `CHK("col", 1'b0, col)
    `CHK("crs", 1'b0, crs)
    chip_rst_low = 1'b1;
    cyc(2);
    `CHK("col", 1'b1, col)
    tx_en = 1'b0;
    rx = 1'b0;
    cyc(1);
  endtask
  initial begin
    cyc(6);
    rst_b = 1'b1;
    cyc(1);
    t_speed();
    t_col10();
    t_fd();
    t_sqe(1'b0);
    t_sqe(1'b1);
    t_100();
    t_rst();
    conclude();
  end
endmodule
